/* inc/pect_pkg.sv */
// Shared constants, types and mode decode for the PWM / event / capture timer
package pect_pkg;

    localparam int COUNT_WIDTH = 16;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] AUX_RESET = 16'h0000;
    // The instruction-cycle tick is the oscillator (sys_clk) divided by ten
    localparam int TC_DIVIDE = 10;

    typedef enum logic [2:0] {
        MODE_EVENT = 3'h1,
        MODE_PWM = 3'h2,
        MODE_CAPTURE = 3'h4
    } pect_mode_e;

    typedef struct packed {
        logic modeBit3;
        logic modeBit2;
        logic modeBit1;
        logic enableA;
        logic enableB;
    } pect_ctrl_s;

    typedef struct packed {
        logic counterWr;
        logic auxAWr;
        logic auxBWr;
        logic runWr;
        logic runVal;
        logic clrPendA;
        logic clrPendB;
        logic [COUNT_WIDTH-1:0] data;
    } pect_sw_s;

    function automatic pect_mode_e pect_decode(input pect_ctrl_s c);
        if (c.modeBit2) begin
            return MODE_CAPTURE;
        end else if (c.modeBit3) begin
            return MODE_PWM;
        end
        return MODE_EVENT;
    endfunction : pect_decode

endpackage : pect_pkg

/* testbench/pect_pin_model.sv */
// Pin-side partner: external edge sources on both pins and a PWM load on pin A
`timescale 1ns/100ps
module pect_pin_model (
    input wire logic sys_clk,
    input wire logic pinAOut,
    input wire logic pinAOe_n,
    input wire logic srcA,
    input wire logic srcB,
    output logic pinAIn,
    output logic pinB,
    output int loadEdges
);
    logic lastA = 1'b0;
    // The source yields pin A while the timer drives it, so the wire never fights
    assign pinAIn = pinAOe_n ? srcA : pinAOut;
    assign pinB = srcB;
    initial loadEdges = 0;
    // The load counts level changes only while the pin is really driven
    always @(posedge sys_clk) begin
        if (!pinAOe_n && pinAOut !== lastA) begin
            loadEdges <= loadEdges + 1;
        end
        lastA <= pinAOut;
    end
endmodule : pect_pin_model

/* testbench/pect_timer_test.sv */
// Self-checking bench for the PWM / event / capture timer
`timescale 1ns/100ps
module pect_timer_test
    import pect_pkg::*;
();
    localparam int TCD = 2;
    localparam logic [6:0] W_CNT = 7'h40;
    localparam logic [6:0] W_A = 7'h20;
    localparam logic [6:0] W_B = 7'h10;
    localparam logic [6:0] RUN1 = 7'h0c;
    localparam logic [6:0] RUN0 = 7'h08;
    localparam logic [6:0] CLRAB = 7'h03;
    localparam logic [6:0] CLRA = 7'h02;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    pect_ctrl_s ctrl = '0;
    pect_sw_s sw = '0;
    logic lowPower = 1'b0;
    logic srcA = 1'b0;
    logic srcB = 1'b0;
    logic pinAIn, pinAOut, pinAOe_n, pinB, runOrUnderflowPend;
    logic pendingA, pendingB, irqA, irqB, snapBit;
    logic [COUNT_WIDTH-1:0] counter, auxRegA, auxRegB, snap;
    int loadEdges;
    int failCount = 0;
    int comparisons = 0;

    pect_timer #(.TC_DIV(TCD)) u_pect_timer (.sys_clk(sys_clk), .reset(reset), .ctrl(ctrl),
        .sw(sw), .lowPower(lowPower), .pinAIn(pinAIn), .pinAOut(pinAOut), .pinAOe_n(pinAOe_n),
        .pinB(pinB), .counter(counter), .auxRegA(auxRegA), .auxRegB(auxRegB),
        .runOrUnderflowPend(runOrUnderflowPend), .pendingA(pendingA), .pendingB(pendingB),
        .irqA(irqA), .irqB(irqB));
    pect_pin_model u_pect_pin_model (.sys_clk(sys_clk), .pinAOut(pinAOut),
        .pinAOe_n(pinAOe_n), .srcA(srcA), .srcB(srcB), .pinAIn(pinAIn), .pinB(pinB),
        .loadEdges(loadEdges));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    // One-cycle software strobe; all strobes in a word share the data
    task automatic wr(input logic [6:0] st, input logic [15:0] d);
        @(posedge sys_clk);
        sw <= {st, d};
        @(posedge sys_clk);
        sw <= '0;
        #1;
    endtask : wr

    task automatic setc(input logic [4:0] c);
        @(posedge sys_clk);
        ctrl <= c;
        #1;
    endtask : setc

    // Eight cycles cover the filter latency plus the cycle the edge acts
    task automatic pin(input logic a, input logic b);
        @(posedge sys_clk);
        srcA <= a;
        srcB <= b;
        cyc(8);
    endtask : pin

    task automatic wait_flag(input int which);
        int n;
        logic f;
        n = 0;
        f = 1'b0;
        while (f !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            f = which == 0 ? pendingA : which == 1 ? pendingB : runOrUnderflowPend;
            n++;
            if (n > 300) begin
                failCount++;
                $display("MISMATCH t=%0t flag %0d never set", $time, which);
                finish_test();
            end
        end
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        cyc(1);
        check({pinAOe_n, irqA, irqB, pendingA, pendingB}, 16'h0010);
        // PWM with toggle, both interrupts enabled
        setc(5'h17);
        wr(W_A, 16'h0003);
        wr(W_B, 16'h0006);
        wr(W_CNT, 16'h0000);
        wr(RUN1, 16'h0000);
        wait_flag(0);
        check(counter, 16'h0003);
        check(pendingB, 0);
        check(pinAOe_n, 0);
        snapBit = ~pinAOut;
        wait_flag(1);
        check(counter, 16'h0006);
        check(pinAOut, snapBit);
        cyc(2);
        // The load registers the second toggle one edge after the flag shows
        check(loadEdges >= 2, 1);
        check({irqA, irqB}, 16'h0003);
        wr(CLRA, 16'h0000);
        check(pendingA, 0);
        cyc(1);
        check(irqA, 0);
        wait_flag(0);
        check(counter, 16'h0003);
        check(pendingB, 1);
        setc(5'h13);
        cyc(2);
        check(pinAOe_n, 1);
        wr(RUN0, 16'h0000);
        snap = counter;
        cyc(10);
        check(counter, snap);
        wr(RUN1, 16'h0000);
        @(posedge sys_clk);
        lowPower <= 1'b1;
        cyc(2);
        snap = counter;
        cyc(20);
        check(counter, snap);
        @(posedge sys_clk);
        lowPower <= 1'b0;
        cyc(10);
        check(counter != snap, 1);
        // Event counting, rising then falling edges
        setc(5'h02);
        wr(CLRAB, 16'h0000);
        wr(W_CNT, 16'h0001);
        pin(1, 0);
        pin(0, 0);
        check(counter, 16'h0000);
        check(pendingA, 0);
        pin(1, 0);
        check(counter, 16'hffff);
        check({pendingA, irqA}, 16'h0003);
        check(pinAOe_n, 1);
        // Clear lands on the edge where the pin B rise sets the flag; the set must win
        @(posedge sys_clk);
        srcB <= 1'b1;
        cyc(2);
        wr(CLRAB, 16'h0000);
        check({pendingB, irqB}, 16'h0002);
        setc(5'h06);
        wr(W_CNT, 16'h0005);
        pin(0, 1);
        pin(1, 1);
        check(counter, 16'h0004);
        // Capture, run bit cleared on entry
        setc(5'h0b);
        wr(RUN0 | CLRAB, 16'h0000);
        wr(W_CNT, 16'h8000);
        snap = counter;
        cyc(10);
        check(counter != snap, 1);
        for (int e = 0; e < 4; e++) begin
            setc({e[1], 1'b1, e[0], 2'h3});
            pin(e[0], e[1]);
            wr(CLRAB, 16'h0000);
            @(posedge sys_clk);
            srcA <= !e[0];
            wait_flag(0);
            check(auxRegA - counter < 2, 1);
            check(pendingB, 0);
            @(posedge sys_clk);
            srcB <= !e[1];
            wait_flag(1);
            check(auxRegB - counter < 2, 1);
            cyc(2);
            check({irqA, irqB}, 16'h0003);
            wr(CLRAB, 16'h0000);
            pin(e[0], e[1]);
            check({pendingA, pendingB}, 16'h0000);
        end
        wr(W_CNT, 16'h0003);
        wait_flag(2);
        cyc(2);
        check({pendingA, irqA}, 16'h0001);
        finish_test();
    end
endmodule : pect_timer_test

/* verilog/pect_pin_filter.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pect_pin_filter (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;
    logic agree;

    // First stage feeds only the second; the filter looks at stages two and three
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= pinIn;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign agree = (sync2_reg == sync3_reg);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_reg <= 1'b0;
        end else if (agree) begin
            level_reg <= sync3_reg;
        end
    end

    assign level = level_reg;
    assign rise = agree && sync3_reg && !level_reg;
    assign fall = agree && !sync3_reg && level_reg;

endmodule : pect_pin_filter

/* verilog/pect_timer.sv */
// 16-bit timer block: PWM with alternating reload, event counting, dual capture
`timescale 1ns/100ps
module pect_timer
    import pect_pkg::*;
#(
    parameter int TC_DIV = TC_DIVIDE
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire pect_ctrl_s ctrl,
    input wire pect_sw_s sw,
    input wire logic lowPower,
    input wire logic pinAIn,
    output logic pinAOut,
    output logic pinAOe_n,
    input wire logic pinB,
    output logic [COUNT_WIDTH-1:0] counter,
    output logic [COUNT_WIDTH-1:0] auxRegA,
    output logic [COUNT_WIDTH-1:0] auxRegB,
    output logic runOrUnderflowPend,
    output logic pendingA,
    output logic pendingB,
    output logic irqA,
    output logic irqB
);

    localparam int TICK_W = $clog2(TC_DIV);

    logic [TICK_W-1:0] tickCnt_reg;
    logic [TICK_W-1:0] tickCnt_next;
    logic [COUNT_WIDTH-1:0] counter_reg;
    logic [COUNT_WIDTH-1:0] auxA_reg;
    logic [COUNT_WIDTH-1:0] auxB_reg;
    logic run_reg;
    logic pendA_reg;
    logic pendB_reg;
    logic fromB_reg;
    logic pwmLevel_reg;
    logic pinAOe_n_reg;
    logic irqA_reg;
    logic irqB_reg;
    pect_mode_e mode;
    logic tcTick;
    logic aRise;
    logic aFall;
    logic bRise;
    logic bFall;
    logic atZero;
    logic pwmStep;
    logic evtStep;
    logic capStep;
    logic step;
    logic underflow;
    logic pwmUnder;
    logic capEdgeA;
    logic capEdgeB;
    logic evtEdgeB;
    logic setPendA;
    logic setPendB;

    ////////////////////////////////////////////////////////////////////////////
    // Pin conditioning

    pect_pin_filter u_pin_a (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(pinAIn),
        .level(),
        .rise(aRise),
        .fall(aFall)
    );

    pect_pin_filter u_pin_b (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(pinB),
        .level(),
        .rise(bRise),
        .fall(bFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Instruction-cycle tick; the divider stops too so a resume keeps phase

    assign tcTick = !lowPower && (tickCnt_reg == TICK_W'(TC_DIV - 1));
    assign tickCnt_next = tcTick ? '0 : tickCnt_reg + 1'b1;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tickCnt_reg <= '0;
        end else if (!lowPower) begin
            tickCnt_reg <= tickCnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and count events

    assign mode = pect_decode(ctrl);
    assign atZero = (counter_reg == COUNT_ZERO);
    assign pwmStep = (mode == MODE_PWM) && run_reg && tcTick;
    assign evtStep = (mode == MODE_EVENT) && run_reg && !lowPower
        && (ctrl.modeBit1 ? aFall : aRise);
    assign capStep = (mode == MODE_CAPTURE) && tcTick;
    assign step = pwmStep || evtStep || capStep;
    assign underflow = step && atZero;
    assign pwmUnder = pwmStep && atZero;
    assign capEdgeA = (mode == MODE_CAPTURE) && !lowPower
        && (ctrl.modeBit1 ? aFall : aRise);
    assign capEdgeB = (mode == MODE_CAPTURE) && !lowPower
        && (ctrl.modeBit3 ? bFall : bRise);
    assign evtEdgeB = (mode == MODE_EVENT) && !lowPower && bRise;

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    // Reset value is only for clean simulation; software loads it before use
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            counter_reg <= COUNT_RESET;
        end else if (sw.counterWr) begin
            counter_reg <= sw.data;
        end else if (pwmUnder) begin
            counter_reg <= fromB_reg ? auxB_reg : auxA_reg;
        end else if (step) begin
            counter_reg <= counter_reg - 1'b1;
        end
    end

    // Cleared while stopped so the first reload after a start uses A
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fromB_reg <= 1'b0;
        end else if ((mode != MODE_PWM) || !run_reg) begin
            fromB_reg <= 1'b0;
        end else if (pwmUnder) begin
            fromB_reg <= !fromB_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary registers; a capture beats a software write in the same cycle

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            auxA_reg <= AUX_RESET;
        end else if (capEdgeA) begin
            auxA_reg <= counter_reg;
        end else if (sw.auxAWr) begin
            auxA_reg <= sw.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            auxB_reg <= AUX_RESET;
        end else if (capEdgeB) begin
            auxB_reg <= counter_reg;
        end else if (sw.auxBWr) begin
            auxB_reg <= sw.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags; a hardware set always wins over a clear in the same cycle

    assign setPendA = (pwmUnder && !fromB_reg)
        || ((mode == MODE_EVENT) && underflow)
        || capEdgeA;
    assign setPendB = (pwmUnder && fromB_reg)
        || evtEdgeB
        || capEdgeB;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendA_reg <= 1'b0;
        end else if (setPendA) begin
            pendA_reg <= 1'b1;
        end else if (sw.clrPendA) begin
            pendA_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendB_reg <= 1'b0;
        end else if (setPendB) begin
            pendB_reg <= 1'b1;
        end else if (sw.clrPendB) begin
            pendB_reg <= 1'b0;
        end
    end

    // Bit0 doubles as run control and capture underflow flag; software clears it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_reg <= 1'b0;
        end else if ((mode == MODE_CAPTURE) && underflow) begin
            run_reg <= 1'b1;
        end else if (sw.runWr) begin
            run_reg <= sw.runVal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin A output: driven only in PWM toggle mode

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwmLevel_reg <= 1'b0;
        end else if (pwmUnder && ctrl.modeBit1) begin
            pwmLevel_reg <= !pwmLevel_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinAOe_n_reg <= 1'b1;
        end else begin
            pinAOe_n_reg <= !((mode == MODE_PWM) && ctrl.modeBit1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqA_reg <= 1'b0;
            irqB_reg <= 1'b0;
        end else begin
            irqA_reg <= ctrl.enableA
                && (pendA_reg || ((mode == MODE_CAPTURE) && run_reg));
            irqB_reg <= ctrl.enableB && pendB_reg;
        end
    end

    assign pinAOut = pwmLevel_reg;
    assign pinAOe_n = pinAOe_n_reg;
    assign counter = counter_reg;
    assign auxRegA = auxA_reg;
    assign auxRegB = auxB_reg;
    assign runOrUnderflowPend = run_reg;
    assign pendingA = pendA_reg;
    assign pendingB = pendB_reg;
    assign irqA = irqA_reg;
    assign irqB = irqB_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_pwm_reload_src: assert property (
        pwmUnder && !sw.counterWr |=> counter_reg == $past(fromB_reg ? auxB_reg : auxA_reg))
        else $error("PWM reload took the wrong source");

    a_pwm_alternate: assert property (
        pwmUnder && !fromB_reg && (mode == MODE_PWM) ##1 run_reg && (mode == MODE_PWM)
        |-> fromB_reg)
        else $error("PWM reload did not alternate to B");

    a_pwm_flag_src: assert property (
        pwmUnder |=> ($past(fromB_reg) ? pendB_reg : pendA_reg))
        else $error("PWM underflow set the wrong pending flag");

    a_pend_hold: assert property (
        pendA_reg && !sw.clrPendA |=> pendA_reg)
        else $error("Pending A dropped without a clear");

    a_set_wins: assert property (
        setPendB && sw.clrPendB |=> pendB_reg)
        else $error("Clear beat a simultaneous set of pending B");

    a_irq_follow: assert property (
        1'b1 |=> irqA_reg == $past(ctrl.enableA
            && (pendA_reg || ((mode == MODE_CAPTURE) && run_reg))))
        else $error("Interrupt A does not follow enable and pending");

    a_pin_quiet: assert property (
        (mode == MODE_EVENT) |=> pinAOe_n_reg)
        else $error("Pin A driven in event mode");

    a_toggle_edge: assert property (
        pwmUnder && ctrl.modeBit1 |=> pwmLevel_reg != $past(pwmLevel_reg))
        else $error("Pin A did not toggle on PWM underflow");

    a_stop_hold: assert property (
        (mode != MODE_CAPTURE) && !run_reg && !sw.counterWr |=> $stable(counter_reg))
        else $error("Counter moved while stopped");

    a_cap_run: assert property (
        capStep && !sw.counterWr |=> counter_reg == $past(counter_reg) - 16'h0001)
        else $error("Capture mode counter did not step");

    a_cap_copy: assert property (
        capEdgeA |=> auxA_reg == $past(counter_reg) && pendA_reg)
        else $error("Capture A did not copy the counter");

    a_cap_under: assert property (
        (mode == MODE_CAPTURE) && underflow |=> run_reg)
        else $error("Capture underflow flag not set");

    a_low_freeze: assert property (
        lowPower && !sw.counterWr && !sw.auxAWr && !sw.clrPendA
        |=> $stable(counter_reg) && $stable(auxA_reg) && $stable(pendA_reg))
        else $error("Timer state changed in low power");

    c_pwm_toggle: cover property (pwmUnder && ctrl.modeBit1 && fromB_reg);
    c_evt_under: cover property ((mode == MODE_EVENT) && underflow);
    c_cap_both: cover property (capEdgeA ##[1:200] capEdgeB);
    c_cap_under: cover property ((mode == MODE_CAPTURE) && underflow);

endmodule : pect_timer
